// *** logic/package_power_limit_services.sv ***
// power control unit side of the package power limit services
// holds the turbo limit word, counters, notify ceiling and debug reads
// assumes a decoded request port from the link logic, one cycle per request
`default_nettype none
module package_power_limit_services
    import pkg_power_services_pkg::*;
(
    // clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    // host request port
    input  wire logic        req_valid_in,
    input  wire logic        req_write_in,
    input  wire logic [3:0]  req_service_in,
    input  wire logic [15:0] req_param_in,
    input  wire logic [31:0] req_wdata_in,
    // host answer port
    output logic             ans_valid_out,
    output logic [1:0]       ans_status_out,
    output logic [31:0]      ans_rdata_out,
    // package activity inputs
    input  wire logic [14:0] package_power_in,
    input  wire logic [7:0]  os_pstate_req_in,
    input  wire logic        productive_cycle_in,
    input  wire logic [7:0]  boost_pstate_in,
    input  wire logic [7:0]  limited_pstate_in,
    // debug sources
    input  wire logic [7:0]  agent_enable_in,
    input  wire logic [31:0] table_rdata_in,
    input  wire logic        internal_error_in,
    input  wire logic [3:0]  error_core_in,
    input  wire logic [15:0] thermal_margin_in,
    // debug table address
    output logic [1:0]       table_bank_out,
    output logic [4:0]       table_index_out,
    output logic [2:0]       table_agent_out,
    // power control outputs
    output logic [7:0]       granted_pstate_out,
    output logic             boost_out,
    output logic             limit_active_out
);
    // limit word and control state
    logic [63:0] limit_word_reg;
    logic [63:0] limit_word_next;
    logic [7:0]  notify_reg;
    logic [7:0]  notify_next;
    logic        err_seen_reg;
    logic        err_seen_next;
    logic [3:0]  err_core_reg;
    logic [3:0]  err_core_next;
    logic [INTERNAL_ERROR_SIGNAL_CNT_W-1:0] err_cnt_reg;
    logic [INTERNAL_ERROR_SIGNAL_CNT_W-1:0] err_cnt_next;
    // answer state
    logic        ans_valid_reg;
    logic        ans_valid_next;
    logic [1:0]  ans_status_reg;
    logic [1:0]  ans_status_next;
    logic [31:0] ans_rdata_reg;
    logic [31:0] ans_rdata_next;
    logic [1:0]  bank_reg;
    logic [1:0]  bank_next;
    logic [4:0]  index_reg;
    logic [4:0]  index_next;
    logic [2:0]  agent_reg;
    logic [2:0]  agent_next;
    // control outputs
    logic [7:0]  granted_reg;
    logic [7:0]  granted_next;
    logic        boost_reg;
    logic        boost_next;
    logic        limit_reg;
    logic        limit_next;
    // counters, count enable and limit compares
    logic [31:0] below_time;
    logic [31:0] productive_count;
    logic        below_req;
    logic        over1;
    logic        over2;
    logic        clamp_any;

    assign over1 = limit_word_reg[LIM1_EN_BIT]
                   && (package_power_in > limit_word_reg[LIM1_VAL_MSB:0]);
    assign over2 = limit_word_reg[LIM2_EN_BIT]
                   && (package_power_in > limit_word_reg[LIM2_VAL_MSB:LIM2_VAL_LSB]);
    assign clamp_any = (over1 && limit_word_reg[LIM1_CLAMP_BIT])
                       || (over2 && limit_word_reg[LIM2_CLAMP_BIT]);
    // time spent below the requested state
    assign below_req = (granted_reg < os_pstate_req_in);

    wrap_counter u_below_time (
        .mclk_in   (mclk_in),
        .rst_n_in  (rst_n_in),
        .count_in  (below_req),
        .value_out (below_time)
    );

    wrap_counter u_productive (
        .mclk_in   (mclk_in),
        .rst_n_in  (rst_n_in),
        .count_in  (productive_cycle_in),
        .value_out (productive_count)
    );

    // register writes, first-error capture and read answers
    always_comb
    begin
        limit_word_next = limit_word_reg;
        notify_next     = notify_reg;
        err_seen_next   = err_seen_reg;
        err_core_next   = err_core_reg;
        err_cnt_next    = err_cnt_reg;
        ans_valid_next  = 1'b0;
        ans_status_next = ANS_OK;
        ans_rdata_next  = ans_rdata_reg;
        bank_next       = bank_reg;
        index_next      = index_reg;
        agent_next      = agent_reg;

        // capture first core, then count settle time
        if (internal_error_in && !err_seen_reg)
        begin
            err_seen_next = 1'b1;
            err_core_next = error_core_in;
        end
        if (err_seen_reg && (err_cnt_reg < INTERNAL_ERROR_SIGNAL_CNT_W'(INTERNAL_ERROR_SIGNAL_SETTLE_CYC)))
        begin
            err_cnt_next = err_cnt_reg + INTERNAL_ERROR_SIGNAL_CNT_W'(1);
        end

        if (req_valid_in)
        begin
            ans_valid_next = 1'b1;
            ans_rdata_next = 32'h0000_0000;
            if (req_service_in == SVC_LIMIT_LOW)
            begin
                // first window passes in bits 23:17
                if (req_write_in)
                begin
                    limit_word_next[31:0] = req_wdata_in & HALF_WRITE_MASK;
                end
                ans_rdata_next = limit_word_reg[31:0];
            end
            else if (req_service_in == SVC_LIMIT_HIGH)
            begin
                // second window kept raw in ms
                if (req_write_in)
                begin
                    limit_word_next[63:32] = req_wdata_in & HALF_WRITE_MASK;
                end
                ans_rdata_next = limit_word_reg[63:32];
            end
            else if (req_service_in == SVC_PERF_STATUS && !req_write_in)
            begin
                ans_rdata_next = below_time;
            end
            else if (req_service_in == SVC_PRODUCTIVE && !req_write_in)
            begin
                ans_rdata_next = productive_count;
            end
            else if (req_service_in == SVC_NOTIFY)
            begin
                if (req_write_in)
                begin
                    notify_next = req_wdata_in[7:0];
                end
                ans_rdata_next = {24'h00_0000, notify_reg};
            end
            else if (req_service_in == SVC_REQ_TABLE && !req_write_in)
            begin
                if (req_param_in[PARAM_MODE_BIT])
                begin
                    ans_rdata_next = {23'h00_0000,
                        (err_cnt_reg >= INTERNAL_ERROR_SIGNAL_CNT_W'(INTERNAL_ERROR_SIGNAL_SETTLE_CYC)), 4'h0, err_core_reg};
                end
                else if (req_param_in[PARAM_BANK_MSB:0] < 2'(BANK_COUNT)
                         && req_param_in[PARAM_INDEX_MSB:PARAM_INDEX_LSB] < 5'(INDEX_COUNT))
                begin
                    bank_next  = req_param_in[PARAM_BANK_MSB:0];
                    index_next = req_param_in[PARAM_INDEX_MSB:PARAM_INDEX_LSB];
                    agent_next = req_param_in[PARAM_AGENT_LSB+2:PARAM_AGENT_LSB];
                    if (!req_param_in[PARAM_AGENT_MSB]
                        && agent_enable_in[req_param_in[PARAM_AGENT_LSB+2:PARAM_AGENT_LSB]])
                    begin
                        ans_rdata_next = table_rdata_in;
                    end
                end
                else
                begin
                    ans_status_next = ANS_INVALID;
                end
            end
            else if (req_service_in == SVC_THERMAL_MARGIN && !req_write_in)
            begin
                ans_rdata_next = {{16{thermal_margin_in[15]}}, thermal_margin_in};
            end
            else
            begin
                ans_status_next = ANS_INVALID;
            end
        end
    end

    // performance state grant
    always_comb
    begin
        granted_next = os_pstate_req_in;
        boost_next   = 1'b0;
        limit_next   = over1 || over2;
        if (os_pstate_req_in > notify_reg)
        begin
            boost_next   = 1'b1;
            granted_next = boost_pstate_in;
        end
        if (clamp_any)
        begin
            // no boost while limited, never above the request
            boost_next = 1'b0;
            if (granted_next > os_pstate_req_in)
            begin
                granted_next = os_pstate_req_in;
            end
            if (limited_pstate_in < granted_next)
            begin
                granted_next = limited_pstate_in;
            end
        end
        else if (limit_next)
        begin
            // unclamped limit only removes boost
            boost_next = 1'b0;
            if (granted_next > os_pstate_req_in)
            begin
                granted_next = os_pstate_req_in;
            end
        end
    end

    // state registers
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            // limits off, first limit at design power
            limit_word_reg <= {49'h0, TDP_DEFAULT};
            notify_reg     <= NOTIFY_RESET;
            err_seen_reg   <= 1'b0;
            err_core_reg   <= 4'h0;
            err_cnt_reg    <= '0;
            ans_valid_reg  <= 1'b0;
            ans_status_reg <= ANS_OK;
            ans_rdata_reg  <= 32'h0000_0000;
            bank_reg       <= 2'h0;
            index_reg      <= 5'h00;
            agent_reg      <= 3'h0;
            granted_reg    <= 8'h00;
            boost_reg      <= 1'b0;
            limit_reg      <= 1'b0;
        end
        else
        begin
            limit_word_reg <= limit_word_next;
            notify_reg     <= notify_next;
            err_seen_reg   <= err_seen_next;
            err_core_reg   <= err_core_next;
            err_cnt_reg    <= err_cnt_next;
            ans_valid_reg  <= ans_valid_next;
            ans_status_reg <= ans_status_next;
            ans_rdata_reg  <= ans_rdata_next;
            bank_reg       <= bank_next;
            index_reg      <= index_next;
            agent_reg      <= agent_next;
            granted_reg    <= granted_next;
            boost_reg      <= boost_next;
            limit_reg      <= limit_next;
        end
    end

    // outputs straight from flops
    assign ans_valid_out      = ans_valid_reg;
    assign ans_status_out     = ans_status_reg;
    assign ans_rdata_out      = ans_rdata_reg;
    assign table_bank_out     = bank_reg;
    assign table_index_out    = index_reg;
    assign table_agent_out    = agent_reg;
    assign granted_pstate_out = granted_reg;
    assign boost_out          = boost_reg;
    assign limit_active_out   = limit_reg;
endmodule : package_power_limit_services
`default_nettype wire

// *** logic/pkg_power_services_pkg.sv ***
// package holding service codes, field layout and reset values for the
// package power limit services block
// assumes a decoded host request port in the mclk_in domain
`default_nettype none
package pkg_power_services_pkg;
    // service selectors carried on the host request port
    localparam logic [3:0] SVC_LIMIT_LOW     = 4'h0;
    localparam logic [3:0] SVC_LIMIT_HIGH    = 4'h1;
    localparam logic [3:0] SVC_PERF_STATUS   = 4'h2;
    localparam logic [3:0] SVC_PRODUCTIVE    = 4'h3;
    localparam logic [3:0] SVC_NOTIFY        = 4'h4;
    localparam logic [3:0] SVC_REQ_TABLE     = 4'h5;
    localparam logic [3:0] SVC_THERMAL_MARGIN = 4'h6;

    // limit word field layout, lower half
    localparam int LIM1_VAL_MSB  = 14;
    localparam int LIM1_EN_BIT   = 15;
    localparam int LIM1_CLAMP_BIT = 16;
    localparam int WIN1_LSB      = 17;
    localparam int WIN1_MSB      = 23;
    // upper half, positions inside the 64-bit word
    localparam int LIM2_VAL_LSB  = 32;
    localparam int LIM2_VAL_MSB  = 46;
    localparam int LIM2_EN_BIT   = 47;
    localparam int LIM2_CLAMP_BIT = 48;
    localparam int WIN2_LSB      = 49;
    localparam int WIN2_MSB      = 55;
    // writable bits of each half; reserved bits read as zero
    localparam logic [31:0] HALF_WRITE_MASK = 32'h00ff_ffff;

    // reset values
    localparam logic [14:0] TDP_DEFAULT      = 15'h0118;
    localparam logic [7:0]  NOTIFY_RESET     = 8'hff;

    // debug read parameter layout
    localparam int PARAM_BANK_MSB  = 1;
    localparam int PARAM_INDEX_LSB = 2;
    localparam int PARAM_INDEX_MSB = 6;
    localparam int PARAM_AGENT_LSB = 7;
    localparam int PARAM_AGENT_MSB = 10;
    localparam int PARAM_MODE_BIT  = 11;
    localparam int BANK_COUNT      = 3;
    localparam int INDEX_COUNT     = 20;
    localparam int AGENT_COUNT     = 8;

    // first-error identifier settle time
    localparam int CLK_HZ          = 25_000_000;
    localparam int INTERNAL_ERROR_SIGNAL_SETTLE_US  = 1000;
    localparam int INTERNAL_ERROR_SIGNAL_SETTLE_CYC = (CLK_HZ / 1_000_000) * INTERNAL_ERROR_SIGNAL_SETTLE_US;
    localparam int INTERNAL_ERROR_SIGNAL_CNT_W      = 15;

    // answer status
    localparam logic [1:0] ANS_OK      = 2'h0;
    localparam logic [1:0] ANS_INVALID = 2'h1;
endpackage : pkg_power_services_pkg
`default_nettype wire

// *** logic/wrap_counter.sv ***
// free running wrapping 32-bit event counter with count enable
// assumes everything in the mclk_in domain
`default_nettype none
module wrap_counter
    import pkg_power_services_pkg::*;
(
    // clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    // count control
    input  wire logic        count_in,
    output logic [31:0]      value_out
);
    logic [31:0] value_reg;
    logic [31:0] value_next;

    // add one per enabled cycle, wrap silently
    always_comb
    begin
        value_next = value_reg;
        if (count_in)
        begin
            value_next = value_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            value_reg <= 32'h0000_0000;
        end
        else
        begin
            value_reg <= value_next;
        end
    end

    assign value_out = value_reg;
endmodule : wrap_counter
`default_nettype wire

// *** bench/package_power_limit_services_properties.sv ***
// checker for the request, answer and grant ports of the power services block
// assumes it is bound onto package_power_limit_services, one clock domain
`default_nettype none
module package_power_limit_services_props
    import pkg_power_services_pkg::*;
(
    // clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    // watched ports
    input  wire logic        req_valid_in,
    input  wire logic        req_write_in,
    input  wire logic [3:0]  req_service_in,
    input  wire logic [15:0] req_param_in,
    input  wire logic [31:0] table_rdata_in,
    input  wire logic [7:0]  agent_enable_in,
    input  wire logic [7:0]  os_pstate_req_in,
    input  wire logic [7:0]  boost_pstate_in,
    input  wire logic        ans_valid_out,
    input  wire logic [1:0]  ans_status_out,
    input  wire logic [31:0] ans_rdata_out,
    input  wire logic [7:0]  granted_pstate_out,
    input  wire logic        boost_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    // table read qualifiers
    logic tab_rd;
    logic tab_ok;
    logic tab_on;
    assign tab_rd = req_valid_in && !req_write_in && req_service_in == SVC_REQ_TABLE;
    assign tab_ok = req_param_in[1:0] <= 2'h2 && req_param_in[6:2] <= 5'h13;
    assign tab_on = !req_param_in[10] && agent_enable_in[req_param_in[9:7]];
    property p_ans_next;
        req_valid_in |=> ans_valid_out;
    endproperty
    a_ans_next: assert property (p_ans_next) else $error("answer missing");
    property p_ans_cause;
        ans_valid_out |-> $past(req_valid_in);
    endproperty
    a_ans_cause: assert property (p_ans_cause) else $error("answer without request");
    property p_status_idle;
        !ans_valid_out |-> ans_status_out == ANS_OK;
    endproperty
    a_status_idle: assert property (p_status_idle) else $error("status not cleared");
    property p_bad_service;
        req_valid_in && req_service_in > 4'h6 |=> ans_status_out == ANS_INVALID
            && ans_rdata_out == 32'h0;
    endproperty
    a_bad_service: assert property (p_bad_service) else $error("bad service accepted");
    property p_bad_addr;
        tab_rd && !req_param_in[11] && !tab_ok |=> ans_status_out == ANS_INVALID;
    endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("bad table address accepted");
    property p_tab_data;
        tab_rd && !req_param_in[11] && tab_ok && tab_on |=> ans_rdata_out == $past(table_rdata_in);
    endproperty
    a_tab_data: assert property (p_tab_data) else $error("table data wrong");
    property p_tab_off;
        tab_rd && !req_param_in[11] && tab_ok && !tab_on |=> ans_rdata_out == 32'h0;
    endproperty
    a_tab_off: assert property (p_tab_off) else $error("disabled agent data not zero");
    property p_err_mode;
        tab_rd && req_param_in[11] |=> ans_rdata_out[31:9] == 23'h0 && ans_rdata_out[7:4] == 4'h0;
    endproperty
    a_err_mode: assert property (p_err_mode) else $error("error mode data wrong");
    property p_half_rsv;
        req_valid_in && req_service_in <= SVC_LIMIT_HIGH |=> ans_rdata_out[31:24] == 8'h00;
    endproperty
    a_half_rsv: assert property (p_half_rsv) else $error("reserved limit bits set");
    property p_boost_grant;
        boost_out |-> granted_pstate_out == $past(boost_pstate_in);
    endproperty
    a_boost_grant: assert property (p_boost_grant) else $error("boost grant wrong");
    property p_no_excess;
        !boost_out |-> granted_pstate_out <= $past(os_pstate_req_in);
    endproperty
    a_no_excess: assert property (p_no_excess) else $error("grant above request");
    // main scenarios
    c_boost: cover property (boost_out);
    c_clamped: cover property (granted_pstate_out < os_pstate_req_in);
    c_invalid: cover property (ans_valid_out && ans_status_out == ANS_INVALID);
endmodule : package_power_limit_services_props
bind package_power_limit_services package_power_limit_services_props u_props (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
    .req_write_in(req_write_in), .req_service_in(req_service_in), .req_param_in(req_param_in),
    .table_rdata_in(table_rdata_in), .agent_enable_in(agent_enable_in),
    .os_pstate_req_in(os_pstate_req_in), .boost_pstate_in(boost_pstate_in),
    .ans_valid_out(ans_valid_out), .ans_status_out(ans_status_out),
    .ans_rdata_out(ans_rdata_out), .granted_pstate_out(granted_pstate_out),
    .boost_out(boost_out));
`default_nettype wire

// *** bench/host_link_model.sv ***
// host side model: one request per access, answer collected, table data source
// assumes the design takes requests on the rising edge of mclk_in
`default_nettype none
module host_link_model
(
    // clock
    input  wire logic        mclk_in,
    // request side
    output logic             req_valid_out,
    output logic             req_write_out,
    output logic [3:0]       req_service_out,
    output logic [15:0]      req_param_out,
    output logic [31:0]      req_wdata_out,
    output logic [31:0]      table_rdata_out,
    // answer side
    input  wire logic        ans_valid_in,
    input  wire logic [1:0]  ans_status_in,
    input  wire logic [31:0] ans_rdata_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // table contents follow the addressed entry
    assign table_rdata_out = {16'hc3c3, req_param_out};
    initial
    begin
        req_valid_out = 1'b0;
        req_write_out = 1'b0;
        req_service_out = 4'h0;
        req_param_out = 16'h0;
        req_wdata_out = 32'h0;
    end
    // drive on the falling edge, collect the answer within four cycles
    task automatic access(input logic wr, input logic [3:0] svc, input logic [15:0] prm,
        input logic [31:0] wd, output logic [31:0] rd, output logic [1:0] st, output logic tmo);
        int i;
        @(negedge mclk_in);
        req_valid_out = 1'b1;
        req_write_out = wr;
        req_service_out = svc;
        req_param_out = prm;
        req_wdata_out = wd;
        @(negedge mclk_in);
        req_valid_out = 1'b0;
        req_service_out = ~svc;
        req_param_out = ~prm;
        req_wdata_out = ~wd;
        tmo = 1'b1;
        rd = 32'h0;
        st = 2'h0;
        for (i = 0; i < 4 && tmo; i++)
        begin
            if (ans_valid_in === 1'b1)
            begin
                rd = ans_rdata_in;
                st = ans_status_in;
                tmo = 1'b0;
            end
            else
                @(negedge mclk_in);
        end
    endtask : access
endmodule : host_link_model
`default_nettype wire

// *** bench/package_power_limit_services_test.sv ***
// self-checking bench for the package power limit services block
// assumes host_link_model as request driver and a 25 MHz clock
`default_nettype none
module package_power_limit_services_test
    import pkg_power_services_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in = 1'b0, rst_n_in = 1'b0, req_valid, req_write, ans_valid, boost, lim_act;
    logic [3:0] req_service;
    logic [15:0] req_param;
    logic [31:0] req_wdata, table_rdata, ans_rdata, rd, p0;
    logic [1:0] ans_status, st, tbank;
    logic [14:0] power = 15'h0;
    logic [7:0] os_req = 8'h0, boost_ps = 8'h30, lim_ps = 8'h08, agent_en = 8'h0b, granted;
    logic prod = 1'b0, internal_error_signal = 1'b0;
    logic [3:0] core = 4'h5;
    logic [15:0] margin = 16'hfe40;
    logic [4:0] tindex;
    logic [2:0] tagent;
    int n_fail = 0, samples_checked = 0;
    // clock at 40 ns period
    always #20 mclk_in = ~mclk_in;
    host_link_model u_host_link_model (.mclk_in(mclk_in), .req_valid_out(req_valid),
        .req_write_out(req_write), .req_service_out(req_service), .req_param_out(req_param),
        .req_wdata_out(req_wdata), .table_rdata_out(table_rdata), .ans_valid_in(ans_valid),
        .ans_status_in(ans_status), .ans_rdata_in(ans_rdata));
    package_power_limit_services u_package_power_limit_services (.mclk_in(mclk_in),
        .rst_n_in(rst_n_in), .req_valid_in(req_valid), .req_write_in(req_write),
        .req_service_in(req_service), .req_param_in(req_param), .req_wdata_in(req_wdata),
        .ans_valid_out(ans_valid), .ans_status_out(ans_status), .ans_rdata_out(ans_rdata),
        .package_power_in(power), .os_pstate_req_in(os_req), .productive_cycle_in(prod),
        .boost_pstate_in(boost_ps), .limited_pstate_in(lim_ps), .agent_enable_in(agent_en),
        .table_rdata_in(table_rdata), .internal_error_in(internal_error_signal), .error_core_in(core),
        .thermal_margin_in(margin), .table_bank_out(tbank), .table_index_out(tindex),
        .table_agent_out(tagent), .granted_pstate_out(granted), .boost_out(boost),
        .limit_active_out(lim_act));
    // verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    // compare seen against expected
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // one host access, a lost answer ends the run
    task automatic acc(input logic wr, input logic [3:0] svc, input logic [15:0] prm,
        input logic [31:0] wd);
        logic tmo;
        u_host_link_model.access(wr, svc, prm, wd, rd, st, tmo);
        if (tmo)
        begin
            n_fail++;
            tally_and_finish();
        end
    endtask : acc
    // main sequence
    initial
    begin
        repeat (20) @(negedge mclk_in);
        rst_n_in = 1'b1;
        acc(0, SVC_LIMIT_LOW, 16'h0, 32'h0);
        chk(rd, 32'h0000_0118);
        chk({31'h0, lim_act}, 32'h0);
        acc(0, SVC_LIMIT_HIGH, 16'h0, 32'h0);
        chk(rd, 32'h0);
        $display("test reset_values done");
        power = 15'h0200;
        os_req = 8'h20;
        acc(1, SVC_LIMIT_LOW, 16'h0, 32'hff14_8100);
        chk(rd, 32'h0000_0118);
        acc(0, SVC_LIMIT_LOW, 16'h0, 32'h0);
        chk(rd, 32'h0014_8100);
        acc(1, SVC_LIMIT_HIGH, 16'h0, 32'hee0a_0134);
        acc(0, SVC_LIMIT_HIGH, 16'h0, 32'h0);
        chk(rd, 32'h000a_0134);
        repeat (3) @(negedge mclk_in);
        chk({31'h0, lim_act}, 32'h1);
        chk({24'h0, granted}, 32'h20);
        acc(1, SVC_LIMIT_LOW, 16'h0, 32'h0015_8100);
        repeat (3) @(negedge mclk_in);
        chk({24'h0, granted}, 32'h08);
        acc(0, SVC_PERF_STATUS, 16'h0, 32'h0);
        p0 = rd;
        acc(0, SVC_PERF_STATUS, 16'h0, 32'h0);
        chk(rd - p0, 32'h2);
        acc(1, SVC_PERF_STATUS, 16'h0, 32'h0);
        chk({30'h0, st}, {30'h0, ANS_INVALID});
        $display("test limits done");
        acc(1, SVC_NOTIFY, 16'h0, 32'h0000_0010);
        os_req = 8'h10;
        repeat (3) @(negedge mclk_in);
        chk({23'h0, boost, granted}, 32'h008);
        acc(1, SVC_LIMIT_LOW, 16'h0, 32'h0000_0100);
        os_req = 8'h20;
        repeat (3) @(negedge mclk_in);
        chk({23'h0, boost, granted}, 32'h130);
        os_req = 8'h10;
        repeat (3) @(negedge mclk_in);
        chk({23'h0, boost, granted}, 32'h010);
        acc(0, SVC_NOTIFY, 16'h0, 32'h0);
        chk(rd, 32'h10);
        acc(1, SVC_LIMIT_LOW, 16'h0, 32'h0001_8100);
        os_req = 8'h20;
        lim_ps = 8'h28;
        repeat (3) @(negedge mclk_in);
        chk({23'h0, boost, granted}, 32'h020);
        $display("test notify done");
        prod = 1'b1;
        acc(0, SVC_PRODUCTIVE, 16'h0, 32'h0);
        p0 = rd;
        acc(0, SVC_PRODUCTIVE, 16'h0, 32'h0);
        chk(rd - p0, 32'h2);
        prod = 1'b0;
        acc(0, SVC_PRODUCTIVE, 16'h0, 32'h0);
        p0 = rd;
        acc(0, SVC_PRODUCTIVE, 16'h0, 32'h0);
        chk(rd - p0, 32'h0);
        $display("test counters done");
        acc(0, SVC_REQ_TABLE, 16'h01ce, 32'h0);
        chk(rd, 32'hc3c3_01ce);
        chk({22'h0, tagent, tindex, tbank}, 32'h1ce);
        acc(0, SVC_REQ_TABLE, 16'h0100, 32'h0);
        chk(rd, 32'h0);
        acc(0, SVC_REQ_TABLE, 16'h0400, 32'h0);
        chk(rd, 32'h0);
        acc(0, SVC_REQ_TABLE, 16'h0003, 32'h0);
        chk({30'h0, st}, {30'h0, ANS_INVALID});
        acc(0, SVC_REQ_TABLE, 16'h0050, 32'h0);
        chk({30'h0, st}, {30'h0, ANS_INVALID});
        acc(0, 4'h9, 16'h0, 32'h0);
        chk({st, rd}, {ANS_INVALID, 32'h0});
        $display("test table done");
        internal_error_signal = 1'b1;
        repeat (2) @(negedge mclk_in);
        acc(0, SVC_REQ_TABLE, 16'h0fff, 32'h0);
        chk({31'h0, rd[8]}, 32'h0);
        core = 4'h9;
        repeat (INTERNAL_ERROR_SIGNAL_SETTLE_CYC) @(negedge mclk_in);
        acc(0, SVC_REQ_TABLE, 16'h0fff, 32'h0);
        chk(rd, 32'h0000_0105);
        acc(0, SVC_THERMAL_MARGIN, 16'h0, 32'h0);
        chk(rd, 32'hffff_fe40);
        $display("test error_and_margin done");
        tally_and_finish();
    end
endmodule : package_power_limit_services_test
`default_nettype wire
